// >>> include/tacr_params.svh
// constants for the tilt axis calibration register block
// assumes 16-bit register addresses and data from the frame engine
`ifndef TACR_PARAMS_SVH
`define TACR_PARAMS_SVH
// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define TACR_ADDR_X_RANGE  16'h0018
`define TACR_ADDR_Y_ZERO   16'h001e
`define TACR_ADDR_Y_PRESET 16'h001f
`define TACR_ADDR_Y_CORR   16'h0020
`define TACR_ADDR_Y_FLIP   16'h0021
`define TACR_ADDR_STORE    16'h0032
// ----------------------------------------------------------------------------
// command keys and codes
// ----------------------------------------------------------------------------
`define TACR_KEY_ZERO      16'h5a59
`define TACR_KEY_STORE     16'h5354
`define TACR_FLIP_OFF      16'h0001
`define TACR_FLIP_ON       16'h0002
`define TACR_EXC_ADDR      8'h02
`define TACR_EXC_VALUE     8'h03
// ----------------------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------------------
`define TACR_X_MIN         16'h0001
`define TACR_X_MAX_SINGLE  16'h00b4
`define TACR_HALF_SCALE    8'h32
`define TACR_X_RANGE_RST   16'h00b4
`define TACR_Y_CORR_RST    16'h0000
`endif

// >>> include/tacr_pkg.sv
// types of the tilt axis calibration register block
// assumes the constants header sits beside it
package tacr_pkg;
  // one register command from the frame engine
  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [15:0] data;
  } tacr_cmd_t;
  // one register answer
  typedef struct packed {
    logic        err;
    logic [7:0]  code;
    logic [15:0] data;
  } tacr_rsp_t;
  // persisted settings
  typedef struct packed {
    logic [15:0]        x_range;
    logic signed [15:0] y_corr;
    logic               y_flip;
  } tacr_nvm_t;
  // command engine states
  typedef enum logic [0:0] {
    TACR_IDLE,
    TACR_SAVE
  } tacr_state_t;
endpackage : tacr_pkg

// >>> core/tacr_regs.sv
// calibration holding registers of the tilt sensor axes
// assumes a frame engine on the same clock decodes single-register
// commands and pulses rsp_sent when the answer frame has left the wire
`timescale 1ns/10ps
`include "tacr_params.svh"

// What this block does
// - dual-axis X limit 1 to factory range
// - single-axis X limit 1 to 180
// - single-axis limit only on half-circle output
// - X limit is unsigned 16-bit degrees
// - bad X limit answers exception 3
// - new X limit active after answer sent
// - stored X limit reloaded at restart
// - zero key computes Y correction
// - zero trigger reads back zero
// - zero correction is negated flipped raw
// - correction beyond half range gets exception 3
// - zero correction active after answer sent
// - preset correction is preset minus flipped raw
// - preset correction active at once
// - Y functions only on dual-axis units
// - direct correction checked, signed hundredths
// - direct correction active after answer sent
// - stored correction reloaded at restart
// - flip accepts 1 off, 2 on
// - flip applied before adding correction
// - flip immediate, reloaded at restart
// - store key saves, answer after save
module tacr_regs (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // unit variant and measurement
  input  wire logic                dual_axis,       // high on two-axis units
  input  wire logic [15:0]         x_factory_range, // whole degrees
  input  wire logic [15:0]         y_range,         // whole degrees
  input  wire logic signed [15:0]  y_raw_tilt,      // hundredths of a degree
  // command from frame engine
  input  wire logic                cmd_valid,
  input  wire tacr_pkg::tacr_cmd_t cmd,
  output logic                     cmd_ready_q,
  // answer to frame engine
  output logic                     rsp_valid_q,
  output tacr_pkg::tacr_rsp_t      rsp_q,
  input  wire logic                rsp_sent,
  // non-volatile store
  input  wire logic                nvm_load,
  input  wire tacr_pkg::tacr_nvm_t nvm_rd,
  output logic                     nvm_store_q,
  output tacr_pkg::tacr_nvm_t      nvm_wr_q,
  input  wire logic                nvm_done,
  // effective settings
  output logic [15:0]              x_range_q,
  output logic                     x_full_free_q,
  output logic signed [15:0]       y_corr_q,
  output logic                     y_flip_q,
  output logic signed [15:0]       y_angle_q
);
  import tacr_pkg::*;

  // --------------------------------------------------------------------------
  // arithmetic
  // --------------------------------------------------------------------------
  logic signed [16:0] flipped;    // raw tilt with sign flip applied
  logic signed [23:0] lim;        // half range in hundredths
  logic signed [23:0] zero_val;   // correction from zero key
  logic signed [23:0] preset_val; // correction from preset
  logic signed [23:0] direct_val; // directly written correction

  // flip comes before the correction is added
  assign flipped    = y_flip_q ? -{y_raw_tilt[15], y_raw_tilt}
                               : {y_raw_tilt[15], y_raw_tilt};
  assign lim        = $signed({2'b00, y_range * 22'(`TACR_HALF_SCALE)});
  assign zero_val   = -{{7{flipped[16]}}, flipped};
  assign preset_val = {{8{cmd.data[15]}}, cmd.data}
                      - {{7{flipped[16]}}, flipped};
  assign direct_val = {{8{cmd.data[15]}}, cmd.data};

  // correction inside plus or minus half the range
  function automatic logic fits(input logic signed [23:0] v,
                                input logic signed [23:0] l);
    fits = (v >= -l) && (v <= l);
  endfunction : fits

  // --------------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------------
  tacr_state_t state_q;      // command engine state
  logic        take;         // command accepted this cycle
  logic        d_err;        // exception answer
  logic [7:0]  d_code;       // exception code
  logic [15:0] d_data;       // read data
  logic        d_wr_x;       // X limit goes pending
  logic        d_wr_ypend;   // correction goes pending
  logic        d_wr_yimm;    // correction taken at once
  logic        d_wr_flip;    // flip taken at once
  logic        d_store;      // store key seen
  logic [15:0] d_yval;       // new correction value
  logic        x_ok;         // X limit valid

  assign take = cmd_valid && cmd_ready_q;

  // X limit check depends on unit variant
  always_comb begin
    if (dual_axis) begin
      x_ok = (cmd.data >= `TACR_X_MIN) && (cmd.data <= x_factory_range);
    end else begin
      x_ok = (cmd.data >= `TACR_X_MIN) && (cmd.data <= `TACR_X_MAX_SINGLE);
    end
  end

  // address decode and value checks
  always_comb begin
    d_err      = 1'b0;
    d_code     = 8'h00;
    d_data     = 16'h0000;
    d_wr_x     = 1'b0;
    d_wr_ypend = 1'b0;
    d_wr_yimm  = 1'b0;
    d_wr_flip  = 1'b0;
    d_store    = 1'b0;
    d_yval     = 16'h0000;
    case (cmd.addr)
      `TACR_ADDR_X_RANGE: begin
        if (!cmd.write) begin
          d_data = x_range_q;
        end else if (x_ok) begin
          d_wr_x = 1'b1;
        end else begin
          d_err  = 1'b1;
          d_code = `TACR_EXC_VALUE;
        end
      end
      `TACR_ADDR_Y_ZERO: begin
        if (!dual_axis) begin
          d_err  = 1'b1;
          d_code = `TACR_EXC_ADDR;
        end else if (!cmd.write) begin
          d_data = 16'h0000;
        end else if (cmd.data != `TACR_KEY_ZERO) begin
          d_data = 16'h0000;
        end else if (fits(zero_val, lim)) begin
          d_wr_ypend = 1'b1;
          d_yval     = zero_val[15:0];
        end else begin
          d_err  = 1'b1;
          d_code = `TACR_EXC_VALUE;
        end
      end
      `TACR_ADDR_Y_PRESET: begin
        if (!dual_axis) begin
          d_err  = 1'b1;
          d_code = `TACR_EXC_ADDR;
        end else if (!cmd.write) begin
          d_data = 16'h0000;
        end else if (fits(preset_val, lim)) begin
          d_wr_yimm = 1'b1;
          d_yval    = preset_val[15:0];
        end else begin
          d_err  = 1'b1;
          d_code = `TACR_EXC_VALUE;
        end
      end
      `TACR_ADDR_Y_CORR: begin
        if (!dual_axis) begin
          d_err  = 1'b1;
          d_code = `TACR_EXC_ADDR;
        end else if (!cmd.write) begin
          d_data = y_corr_q;
        end else if (fits(direct_val, lim)) begin
          d_wr_ypend = 1'b1;
          d_yval     = cmd.data;
        end else begin
          d_err  = 1'b1;
          d_code = `TACR_EXC_VALUE;
        end
      end
      `TACR_ADDR_Y_FLIP: begin
        if (!dual_axis) begin
          d_err  = 1'b1;
          d_code = `TACR_EXC_ADDR;
        end else if (!cmd.write) begin
          d_data = y_flip_q ? `TACR_FLIP_ON : `TACR_FLIP_OFF;
        end else if (cmd.data == `TACR_FLIP_OFF || cmd.data == `TACR_FLIP_ON) begin
          d_wr_flip = 1'b1;
        end else begin
          d_err  = 1'b1;
          d_code = `TACR_EXC_VALUE;
        end
      end
      `TACR_ADDR_STORE: begin
        // write-only: reads and other values answer zero
        d_store = cmd.write && (cmd.data == `TACR_KEY_STORE);
      end
      default: begin
        d_err  = 1'b1;
        d_code = `TACR_EXC_ADDR;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // command engine and answer
  // --------------------------------------------------------------------------
  // store holds the answer until the save completes
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= TACR_IDLE;
      cmd_ready_q <= 1'b0;
      nvm_store_q <= 1'b0;
      nvm_wr_q    <= '0;
    end else begin
      case (state_q)
        TACR_IDLE: begin
          cmd_ready_q <= 1'b1;
          if (take && d_store) begin
            state_q     <= TACR_SAVE;
            cmd_ready_q <= 1'b0;
            nvm_store_q <= 1'b1;
            nvm_wr_q    <= '{x_range: x_range_q, y_corr: y_corr_q, y_flip: y_flip_q};
          end
        end
        TACR_SAVE: begin
          if (nvm_done) begin
            state_q     <= TACR_IDLE;
            cmd_ready_q <= 1'b1;
            nvm_store_q <= 1'b0;
          end
        end
        default: begin
          state_q <= TACR_IDLE;
        end
      endcase
    end
  end

  // answer pulse one cycle after a command, or after the save
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else if (take && !d_store) begin
      rsp_valid_q <= 1'b1;
      rsp_q       <= '{err: d_err, code: d_code, data: d_data};
    end else if (state_q == TACR_SAVE && nvm_done) begin
      rsp_valid_q <= 1'b1;
      rsp_q       <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // pending values waiting for the answer frame
  // --------------------------------------------------------------------------
  logic        pend_x_q;   // X limit waiting
  logic [15:0] pend_xv_q;  // its value
  logic        pend_y_q;   // correction waiting
  logic [15:0] pend_yv_q;  // its value

  // a new write in the same cycle as rsp_sent stays pending
  always_ff @(posedge clk) begin
    if (rst || nvm_load) begin
      pend_x_q  <= 1'b0;
      pend_xv_q <= 16'h0000;
    end else if (take && d_wr_x) begin
      pend_x_q  <= 1'b1;
      pend_xv_q <= cmd.data;
    end else if (rsp_sent) begin
      pend_x_q  <= 1'b0;
    end
  end

  // correction from zero key or direct write
  always_ff @(posedge clk) begin
    if (rst || nvm_load) begin
      pend_y_q  <= 1'b0;
      pend_yv_q <= 16'h0000;
    end else if (take && d_wr_ypend) begin
      pend_y_q  <= 1'b1;
      pend_yv_q <= d_yval;
    end else if (take && d_wr_yimm) begin
      pend_y_q  <= 1'b0;
    end else if (rsp_sent) begin
      pend_y_q  <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // effective settings
  // --------------------------------------------------------------------------
  // X limit: restart load, then commit after the answer
  always_ff @(posedge clk) begin
    if (rst) begin
      x_range_q <= `TACR_X_RANGE_RST;
    end else if (nvm_load) begin
      x_range_q <= nvm_rd.x_range;
    end else if (pend_x_q && rsp_sent) begin
      x_range_q <= pend_xv_q;
    end
  end

  // single-axis full-circle output ignores the limit
  always_ff @(posedge clk) begin
    if (rst) begin
      x_full_free_q <= 1'b1;
    end else begin
      x_full_free_q <= !dual_axis;
    end
  end

  // Y correction: restart load, preset at once, others after the answer
  always_ff @(posedge clk) begin
    if (rst) begin
      y_corr_q <= `TACR_Y_CORR_RST;
    end else if (nvm_load) begin
      y_corr_q <= dual_axis ? nvm_rd.y_corr : `TACR_Y_CORR_RST;
    end else if (take && d_wr_yimm) begin
      y_corr_q <= d_yval;
    end else if (pend_y_q && rsp_sent) begin
      y_corr_q <= pend_yv_q;
    end
  end

  // flip: immediate, reloaded at restart
  always_ff @(posedge clk) begin
    if (rst) begin
      y_flip_q <= 1'b0;
    end else if (nvm_load) begin
      y_flip_q <= dual_axis && nvm_rd.y_flip;
    end else if (take && d_wr_flip) begin
      y_flip_q <= (cmd.data == `TACR_FLIP_ON);
    end
  end

  // corrected Y angle, zero on single-axis units
  always_ff @(posedge clk) begin
    if (rst) begin
      y_angle_q <= 16'h0000;
    end else if (dual_axis) begin
      y_angle_q <= flipped[15:0] + y_corr_q;
    end else begin
      y_angle_q <= 16'h0000;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  x_dual_reject_a: assert property (@(posedge clk) disable iff (rst)
    take && cmd.write && cmd.addr == `TACR_ADDR_X_RANGE && dual_axis
      && cmd.data > x_factory_range
    |=> rsp_valid_q && rsp_q.err && rsp_q.code == 8'h03)
    else $error("dual-axis X limit above factory range not refused");

  x_single_reject_a: assert property (@(posedge clk) disable iff (rst)
    take && cmd.write && cmd.addr == `TACR_ADDR_X_RANGE && !dual_axis
      && (cmd.data > 16'h00b4 || cmd.data == 16'h0000)
    |=> rsp_q.err && rsp_q.code == 8'h03)
    else $error("single-axis X limit out of 1..180 not refused");

  x_defer_a: assert property (@(posedge clk) disable iff (rst)
    take && d_wr_x && !rsp_sent && !nvm_load
    |=> x_range_q == $past(x_range_q) ##0 pend_x_q)
    else $error("X limit took effect before answer sent");

  zero_read_a: assert property (@(posedge clk) disable iff (rst)
    take && !cmd.write && cmd.addr == `TACR_ADDR_Y_ZERO && dual_axis
    |=> rsp_valid_q && rsp_q.data == 16'h0000)
    else $error("zero trigger read not zero");

  commit_y_a: assert property (@(posedge clk) disable iff (rst)
    pend_y_q && rsp_sent && !nvm_load && !take
    |=> y_corr_q == $past(pend_yv_q))
    else $error("pending correction not committed");

  preset_now_a: assert property (@(posedge clk) disable iff (rst)
    take && d_wr_yimm && !nvm_load
    |=> y_corr_q == $past(preset_val[15:0]))
    else $error("preset correction not taken at once");

  flip_code_a: assert property (@(posedge clk) disable iff (rst)
    take && cmd.write && cmd.addr == `TACR_ADDR_Y_FLIP && dual_axis
      && cmd.data != 16'h0001 && cmd.data != 16'h0002
    |=> rsp_q.err && rsp_q.code == 8'h03)
    else $error("bad flip value not refused");

  store_wait_a: assert property (@(posedge clk) disable iff (rst)
    nvm_store_q && !nvm_done |=> !rsp_valid_q && nvm_store_q)
    else $error("answer given before save done");

  angle_sum_a: assert property (@(posedge clk) disable iff (rst)
    dual_axis |=> y_angle_q == $past(flipped[15:0] + y_corr_q))
    else $error("Y angle not flipped raw plus correction");

endmodule : tacr_regs

// >>> verification/tacr_nvm_model.sv
// non-volatile store model facing the calibration registers
// assumes one clock with the design; image survives rst
`timescale 1ns/10ps
module tacr_nvm_model (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // save request from the design
  input  wire logic                nvm_store_q,
  input  wire tacr_pkg::tacr_nvm_t nvm_wr_q,
  input  wire logic [7:0]          lat,      // save time in cycles
  // answers
  output logic                     nvm_done = 1'b0,
  output tacr_pkg::tacr_nvm_t      nvm_rd = {16'h00b4, 16'h0000, 1'b0} // image before any save
);
  import tacr_pkg::*;
  // --------------------------------------------------------------
  // save engine
  // --------------------------------------------------------------
  logic [1:0] ph_q = 2'h0;   // 0 idle, 1 saving, 2 wait release
  logic [7:0] cnt_q = 8'h00; // remaining save cycles
  // done pulses only once the save time has run out
  always @(posedge clk) begin
    nvm_done <= 1'b0;
    if (rst) begin
      ph_q <= 2'h0;
    end else if (ph_q == 2'h0 && nvm_store_q) begin
      ph_q  <= 2'h1;
      cnt_q <= lat;
    end else if (ph_q == 2'h1 && cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (ph_q == 2'h1) begin
      nvm_rd   <= nvm_wr_q;
      nvm_done <= 1'b1;
      ph_q     <= 2'h2;
    end else if (ph_q == 2'h2 && !nvm_store_q) begin
      ph_q <= 2'h0;          // no second save on a held request
    end
  end
endmodule : tacr_nvm_model

// >>> verification/testbench.sv
// self-checking bench of the tilt axis calibration registers
// assumes tacr_pkg compiled first, tacr_params.svh on include path
`timescale 1ns/10ps
`include "tacr_params.svh"
module testbench;
  import tacr_pkg::*;
  // --------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------
  typedef struct packed {
    logic w; logic [15:0] a; logic [15:0] d;
    logic e; logic [7:0] c; logic [15:0] r;
  } tacr_tb_row_t;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               dual_axis = 1'b1;
  logic [15:0]        x_fact = 16'h003c;  // 60 deg factory range
  logic [15:0]        y_range = 16'h000a; // half is 500 hundredths
  logic signed [15:0] y_raw = 16'sh0000;
  logic               cmd_valid = 1'b0;
  tacr_cmd_t          cmd = '0;
  logic               rsp_sent = 1'b0;
  logic               nvm_load = 1'b0;
  logic [7:0]         lat = 8'h1e;        // slow save
  logic               cmd_ready_q, rsp_valid_q, nvm_store_q, nvm_done;
  tacr_rsp_t          rsp_q;
  tacr_nvm_t          nvm_rd, nvm_wr_q;
  logic [15:0]        x_range_q;
  logic               x_full_free_q, y_flip_q;
  logic signed [15:0] y_corr_q, y_angle_q;
  int                 n_mismatch = 0;
  int                 checks_done = 0;
  // ordinary cases: write, address, data, error, code, read data
  tacr_tb_row_t rows [22] = '{
    {1'b1, `TACR_ADDR_X_RANGE, 16'h0001, 1'b0, 8'h00, 16'h0000},
    {1'b1, `TACR_ADDR_X_RANGE, 16'h0000, 1'b1, 8'h03, 16'h0000},
    {1'b1, `TACR_ADDR_X_RANGE, 16'h003c, 1'b0, 8'h00, 16'h0000},
    {1'b1, `TACR_ADDR_X_RANGE, 16'h003d, 1'b1, 8'h03, 16'h0000},
    {1'b0, `TACR_ADDR_X_RANGE, 16'h0000, 1'b0, 8'h00, 16'h003c},
    {1'b1, `TACR_ADDR_Y_FLIP, 16'h0003, 1'b1, 8'h03, 16'h0000},
    {1'b1, `TACR_ADDR_Y_FLIP, 16'h0000, 1'b1, 8'h03, 16'h0000},
    {1'b1, `TACR_ADDR_Y_FLIP, 16'h0002, 1'b0, 8'h00, 16'h0000},
    {1'b0, `TACR_ADDR_Y_FLIP, 16'h0000, 1'b0, 8'h00, 16'h0002},
    {1'b1, `TACR_ADDR_Y_FLIP, 16'h0001, 1'b0, 8'h00, 16'h0000},
    {1'b0, `TACR_ADDR_Y_FLIP, 16'h0000, 1'b0, 8'h00, 16'h0001},
    {1'b0, `TACR_ADDR_Y_ZERO, 16'h0000, 1'b0, 8'h00, 16'h0000},
    {1'b0, `TACR_ADDR_Y_PRESET, 16'h0000, 1'b0, 8'h00, 16'h0000},
    {1'b0, `TACR_ADDR_STORE, 16'h0000, 1'b0, 8'h00, 16'h0000},
    {1'b1, 16'h0019, 16'h0000, 1'b1, 8'h02, 16'h0000},
    {1'b1, `TACR_ADDR_Y_CORR, 16'h01f5, 1'b1, 8'h03, 16'h0000},
    {1'b1, `TACR_ADDR_Y_CORR, 16'hfe0b, 1'b1, 8'h03, 16'h0000},
    {1'b1, `TACR_ADDR_Y_CORR, 16'h01f4, 1'b0, 8'h00, 16'h0000},
    {1'b0, `TACR_ADDR_Y_CORR, 16'h0000, 1'b0, 8'h00, 16'h01f4},
    {1'b1, `TACR_ADDR_Y_CORR, 16'hfe0c, 1'b0, 8'h00, 16'h0000},
    {1'b0, `TACR_ADDR_Y_CORR, 16'h0000, 1'b0, 8'h00, 16'hfe0c},
    {1'b1, `TACR_ADDR_Y_CORR, 16'h0000, 1'b0, 8'h00, 16'h0000}
  };
  // --------------------------------------------------------------
  // design, far-side store and clock
  // --------------------------------------------------------------
  tacr_regs DUT (
    .clk(clk), .rst(rst), .dual_axis(dual_axis),
    .x_factory_range(x_fact), .y_range(y_range), .y_raw_tilt(y_raw),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_q(cmd_ready_q),
    .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q), .rsp_sent(rsp_sent),
    .nvm_load(nvm_load), .nvm_rd(nvm_rd), .nvm_store_q(nvm_store_q),
    .nvm_wr_q(nvm_wr_q), .nvm_done(nvm_done), .x_range_q(x_range_q),
    .x_full_free_q(x_full_free_q), .y_corr_q(y_corr_q),
    .y_flip_q(y_flip_q), .y_angle_q(y_angle_q)
  );
  tacr_nvm_model nvm (
    .clk(clk), .rst(rst), .nvm_store_q(nvm_store_q),
    .nvm_wr_q(nvm_wr_q), .lat(lat), .nvm_done(nvm_done), .nvm_rd(nvm_rd)
  );
  initial begin
    forever #12.5 clk = ~clk;
  end
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // compare one value, report at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one command, entered and left at a falling edge
  task automatic run(input logic w, input logic [15:0] a, input logic [15:0] d);
    int k;
    // one falling edge between calls, so cmd_valid never drops and rises in one step
    @(negedge clk);
    k = 0;
    while (cmd_ready_q !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k >= 100) begin
      n_mismatch++;
      end_sim();
    end
    cmd_valid = 1'b1;
    cmd = '{write: w, addr: a, data: d};
    @(negedge clk);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid_q !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k >= 100) begin
      n_mismatch++;
      end_sim();
    end
  endtask : run
  // write and check error flag and code
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic e, input logic [7:0] c);
    run(1'b1, a, d);
    chk(rsp_q.err, e);
    if (e) chk(rsp_q.code, c);
  endtask : wr
  // frame engine reports the answer frame gone
  task automatic sent();
    rsp_sent = 1'b1;
    @(negedge clk);
    rsp_sent = 1'b0;
    @(negedge clk);
  endtask : sent
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    chk(cmd_ready_q, 16'h0000);
    chk(nvm_store_q, 16'h0000);
    chk(rsp_valid_q, 16'h0000);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(x_range_q, `TACR_X_RANGE_RST);
    chk(y_flip_q, 16'h0000);
    chk(y_corr_q, 16'h0000);
    foreach (rows[i]) begin
      run(rows[i].w, rows[i].a, rows[i].d);
      chk(rsp_q.err, rows[i].e);
      if (rows[i].e) chk(rsp_q.code, rows[i].c);
      else if (!rows[i].w) chk(rsp_q.data, rows[i].r);
      sent();
    end
    // limit waits for its answer frame
    wr(`TACR_ADDR_X_RANGE, 16'h0010, 1'b0, 8'h00);
    chk(x_range_q, 16'h003c);
    sent();
    chk(x_range_q, 16'h0010);
    chk(x_full_free_q, 16'h0000);
    // flip first, then preset acts at once
    y_raw = 16'sh0064;
    wr(`TACR_ADDR_Y_FLIP, `TACR_FLIP_ON, 1'b0, 8'h00);
    chk(y_flip_q, 16'h0001);
    wr(`TACR_ADDR_Y_PRESET, 16'h0032, 1'b0, 8'h00);
    chk(y_corr_q, 16'h0096);
    @(negedge clk);
    chk(y_angle_q, 16'h0032);
    sent();
    chk(y_corr_q, 16'h0096);
    // zero waits for its answer frame
    y_raw = 16'sh00c8;
    wr(`TACR_ADDR_Y_ZERO, `TACR_KEY_ZERO, 1'b0, 8'h00);
    chk(y_corr_q, 16'h0096);
    sent();
    chk(y_corr_q, 16'h00c8);
    chk(y_angle_q, 16'h0000);
    wr(`TACR_ADDR_Y_ZERO, 16'h1234, 1'b0, 8'h00);
    sent();
    chk(y_corr_q, 16'h00c8);
    y_raw = 16'sh0258;
    wr(`TACR_ADDR_Y_ZERO, `TACR_KEY_ZERO, 1'b1, `TACR_EXC_VALUE);
    sent();
    chk(y_corr_q, 16'h00c8);
    // slow save, answer only after it
    wr(`TACR_ADDR_X_RANGE, 16'h0020, 1'b0, 8'h00);
    sent();
    wr(`TACR_ADDR_STORE, `TACR_KEY_STORE, 1'b0, 8'h00);
    chk(nvm_rd.x_range, 16'h0020);
    chk(nvm_rd.y_corr, 16'h00c8);
    chk(nvm_rd.y_flip, 16'h0001);
    chk(nvm_wr_q.x_range, 16'h0020);
    chk(nvm_store_q, 16'h0000);
    // change settings, then restart load
    wr(`TACR_ADDR_X_RANGE, 16'h0005, 1'b0, 8'h00);
    sent();
    wr(`TACR_ADDR_Y_FLIP, `TACR_FLIP_OFF, 1'b0, 8'h00);
    wr(`TACR_ADDR_Y_CORR, 16'h0010, 1'b0, 8'h00);
    sent();
    nvm_load = 1'b1;
    @(negedge clk);
    nvm_load = 1'b0;
    @(negedge clk);
    chk(x_range_q, 16'h0020);
    chk(y_corr_q, 16'h00c8);
    chk(y_flip_q, 16'h0001);
    // single-axis unit
    dual_axis = 1'b0;
    repeat (2) @(negedge clk);
    chk(x_full_free_q, 16'h0001);
    wr(`TACR_ADDR_X_RANGE, `TACR_X_MAX_SINGLE, 1'b0, 8'h00);
    sent();
    chk(x_range_q, 16'h00b4);
    wr(`TACR_ADDR_X_RANGE, 16'h00b5, 1'b1, `TACR_EXC_VALUE);
    wr(`TACR_ADDR_Y_CORR, 16'h0000, 1'b1, `TACR_EXC_ADDR);
    wr(`TACR_ADDR_Y_ZERO, `TACR_KEY_ZERO, 1'b1, `TACR_EXC_ADDR);
    chk(y_angle_q, 16'h0000);
    end_sim();
  end
endmodule : testbench
